// File: mss_defs.svh
// timing counts, widths and field positions for the major-state sequencer
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH
`define MSS_XTAL_HZ        4000000
`define MSS_CLK_HZ         250000000
`define MSS_STATE_NS       500
`define MSS_WAIT_STEP_NS   250
`define MSS_CLK_NS         4
`define MSS_XTAL_DIV       (`MSS_CLK_HZ / `MSS_XTAL_HZ)
`define MSS_WORD_W         12
`define MSS_REQ_W          3
`define MSS_FIFO_DEPTH     8
`define MSS_IOT_OPCODE     3'h6
`define MSS_OP_MSB         11
`define MSS_OP_LSB         9
`define MSS_TGT_MEM        2'h0
`define MSS_TGT_PANEL      2'h1
`define MSS_TGT_SWITCH     2'h2
`endif

// File: mss_pkg.sv
// types shared by the major-state sequencer
`include "mss_defs.svh"
package mss_pkg;
    typedef enum logic [2:0] {
        MSS_IDLE, MSS_T1, MSS_T2, MSS_T3, MSS_T4, MSS_T5, MSS_T6
    } mss_state_t;
    typedef struct packed {
        logic [`MSS_WORD_W-1:0] word;
        logic [`MSS_WORD_W-1:0] wdata;
        logic                   is_iot;
        logic                   do_read;
        logic                   do_write;
        logic [1:0]             target;
        logic                   next_fetch;
    } mss_cycle_t;
    typedef struct packed {
        logic [2:0] csense;
        logic       skip;
    } mss_sense_t;
endpackage

// File: mss_fifo.sv
// cycle request fifo in flip-flops
`timescale 1ns/1ps
module mss_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             rdy_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    wire  [AW:0]      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready  = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_d;
            rdy_q <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule

// File: mss_sequencer.sv
// major-state timing and multiplexed bus-cycle sequencer
`timescale 1ns/1ps
`include "mss_defs.svh"
module mss_sequencer
    import mss_pkg::*;
(
    input  wire logic                   MCLK,
    input  wire logic                   RESET_N,
    input  wire logic [$bits(mss_cycle_t)-1:0] CYCLE_IN,
    input  wire logic                   CYCLE_VALID,
    output logic                        CYCLE_READY,
    input  wire logic [`MSS_WORD_W-1:0] BUS_IN,
    output logic [`MSS_WORD_W-1:0]      BUS_OUT,
    output logic                        BUS_OE,
    output logic                        EXT_ADDR_LOAD_STROBE,
    output logic                        MEMORY_SELECT_N,
    output logic                        DEVICE_SELECT_N,
    output logic                        PANEL_MEMORY_SELECT_N,
    output logic                        SWITCH_REG_SELECT_N,
    input  wire logic                   WAIT_N,
    input  wire logic                   PERIPH_SENSE_0_N,
    input  wire logic                   PERIPH_SENSE_1_N,
    input  wire logic                   PERIPH_SENSE_2_N,
    input  wire logic                   PERIPH_SKIP_SENSE,
    input  wire logic [`MSS_REQ_W-1:0]  REQUEST_N,
    output logic [2:0]                  STATE_STATUS,
    output logic [`MSS_WORD_W-1:0]      READ_DATA,
    output logic                        READ_VALID,
    output logic [3:0]                  SENSE_OUT,
    output logic [`MSS_REQ_W-1:0]       REQUEST_GRANT
);
    localparam int DIV = `MSS_XTAL_DIV;
    localparam int DW  = $clog2(DIV + 1);

    logic       rst_s1_q;
    logic       rst_s2_q;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // pin synchronisers
    localparam int SW = 1 + 4 + `MSS_REQ_W + `MSS_WORD_W;
    logic [SW-1:0] pin_s1_q;
    logic [SW-1:0] pin_s2_q;
    wire  [SW-1:0] pin_raw = {WAIT_N, PERIPH_SENSE_2_N, PERIPH_SENSE_1_N,
                              PERIPH_SENSE_0_N, PERIPH_SKIP_SENSE,
                              REQUEST_N, BUS_IN};
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end
    wire                   wait_act = !pin_s2_q[SW-1];
    wire [2:0]             cs_n     = pin_s2_q[SW-2 -: 3];
    wire                   skip_s   = pin_s2_q[SW-5];
    wire [`MSS_REQ_W-1:0]  req_act  = ~pin_s2_q[`MSS_WORD_W +: `MSS_REQ_W];
    wire [`MSS_WORD_W-1:0] bus_s    = pin_s2_q[`MSS_WORD_W-1:0];

    // crystal tick, state tick
    logic [DW-1:0] div_q;
    logic          half_q;
    wire           xtal_tick = (div_q == DW'(DIV - 1));
    wire           state_tick = xtal_tick && half_q;
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            div_q  <= '0;
            half_q <= 1'b0;
        end else begin
            div_q <= xtal_tick ? '0 : div_q + 1'b1;
            if (xtal_tick) begin
                half_q <= !half_q;
            end
        end
    end

    // request buffer
    mss_cycle_t    fifo_out;
    logic          fifo_valid;
    logic          fifo_ready;
    logic [$bits(mss_cycle_t)-1:0] fifo_raw;
    mss_fifo #(
        .WIDTH ($bits(mss_cycle_t)),
        .DEPTH (`MSS_FIFO_DEPTH)
    ) u_fifo (
        .clk       (MCLK),
        .rst_n     (rst_n),
        .in_data   (CYCLE_IN),
        .in_valid  (CYCLE_VALID),
        .in_ready  (CYCLE_READY),
        .out_data  (fifo_raw),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );
    assign fifo_out = mss_cycle_t'(fifo_raw);

    mss_state_t st_q;
    mss_state_t st_d;
    mss_cycle_t cyc_q;

    function automatic mss_state_t after_t2(input mss_cycle_t c);
        after_t2 = MSS_T3;
    endfunction

    wire t1_end = (st_q == MSS_T1) && state_tick;
    // wait extends only at state boundaries (every second crystal tick)
    wire t2_done = (st_q == MSS_T2) && state_tick && !wait_act;
    wire t6_done = (st_q == MSS_T6) && state_tick && !wait_act;
    assign fifo_ready = (st_q == MSS_IDLE) && state_tick;

    always_comb begin
        st_d = st_q;
        case (st_q)
            MSS_IDLE: if (fifo_ready && fifo_valid) st_d = MSS_T1;
            MSS_T1: begin
                if (t1_end) begin
                    st_d = cyc_q.do_read ? MSS_T2 : MSS_T3;
                end
            end
            MSS_T2: if (t2_done) st_d = after_t2(cyc_q);
            MSS_T3: if (state_tick) st_d = MSS_T4;
            MSS_T4: if (state_tick) st_d = MSS_T5;
            MSS_T5: begin
                if (state_tick) begin
                    st_d = cyc_q.do_write ? MSS_T6 : MSS_IDLE;
                end
            end
            MSS_T6: if (t6_done) st_d = MSS_IDLE;
            default: st_d = MSS_IDLE;
        endcase
    end

    wire sel_phase = (st_q == MSS_T2) || (st_q == MSS_T6);
    wire [1:0] tgt = cyc_q.target;
    wire mem_sel_d = sel_phase && !cyc_q.is_iot
                     && (tgt == `MSS_TGT_MEM);
    wire dev_sel_d = sel_phase && cyc_q.is_iot;
    wire pnl_sel_d = sel_phase && !cyc_q.is_iot
                     && (tgt == `MSS_TGT_PANEL);
    wire swr_sel_d = sel_phase && !cyc_q.is_iot
                     && (tgt == `MSS_TGT_SWITCH);
    // first-state word: address, or the instruction for i/o
    wire [`MSS_WORD_W-1:0] t1_word = cyc_q.word;
    wire [`MSS_REQ_W-1:0]  grant_d = req_act & (~req_act + 1'b1);

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= MSS_IDLE;
            cyc_q <= '0;
        end else begin
            st_q <= st_d;
            if (fifo_ready && fifo_valid) begin
                cyc_q <= fifo_out;
            end
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            BUS_OUT               <= '0;
            BUS_OE                <= 1'b0;
            EXT_ADDR_LOAD_STROBE  <= 1'b0;
            MEMORY_SELECT_N       <= 1'b1;
            DEVICE_SELECT_N       <= 1'b1;
            PANEL_MEMORY_SELECT_N <= 1'b1;
            SWITCH_REG_SELECT_N   <= 1'b1;
            STATE_STATUS          <= 3'h0;
            READ_DATA             <= '0;
            READ_VALID            <= 1'b0;
            SENSE_OUT             <= 4'h0;
            REQUEST_GRANT         <= '0;
        end else begin
            STATE_STATUS <= 3'(st_d);
            // strobe in the first half of the first state
            EXT_ADDR_LOAD_STROBE <= (st_d == MSS_T1) && !half_q
                                    && (st_q != MSS_T1 || !xtal_tick);
            BUS_OE  <= (st_d == MSS_T1) || (st_d == MSS_T6);
            BUS_OUT <= (st_d == MSS_T6) ? cyc_q.wdata : t1_word;
            if (st_q == MSS_IDLE && st_d == MSS_T1) begin
                BUS_OUT <= fifo_out.word;
            end
            MEMORY_SELECT_N       <= !mem_sel_d;
            DEVICE_SELECT_N       <= !dev_sel_d;
            PANEL_MEMORY_SELECT_N <= !pnl_sel_d;
            SWITCH_REG_SELECT_N   <= !swr_sel_d;
            READ_VALID <= t2_done;
            if (t2_done) begin
                READ_DATA <= bus_s;
            end
            if (t2_done && cyc_q.is_iot) begin
                SENSE_OUT <= {~cs_n, skip_s};
            end
            if (t1_end && cyc_q.next_fetch) begin
                REQUEST_GRANT <= grant_d;
            end
        end
    end
endmodule

// File: mss_sequencer_props.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module mss_props (
    input wire logic       MCLK,
    input wire logic       RESET_N,
    input wire logic       WAIT_N,
    input wire logic       BUS_OE,
    input wire logic       EXT_ADDR_LOAD_STROBE,
    input wire logic       MEMORY_SELECT_N,
    input wire logic       DEVICE_SELECT_N,
    input wire logic       PANEL_MEMORY_SELECT_N,
    input wire logic       SWITCH_REG_SELECT_N,
    input wire logic [2:0] STATE_STATUS,
    input wire logic       READ_VALID
);
    logic [2:0] st;
    logic [3:0] sel;
    assign st = STATE_STATUS;
    assign sel = ~{SWITCH_REG_SELECT_N, PANEL_MEMORY_SELECT_N,
                   DEVICE_SELECT_N, MEMORY_SELECT_N};
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    a_strobe_first: assert property (
        EXT_ADDR_LOAD_STROBE |-> st == 3'h1 && BUS_OE)
        else $error("strobe outside first state");
    a_strobe_pulse: assert property (
        $rose(EXT_ADDR_LOAD_STROBE) |-> EXT_ADDR_LOAD_STROBE[*8])
        else $error("strobe pulse too short");
    a_mid_quiet: assert property (
        st inside {3'h3, 3'h4, 3'h5} && $stable(st) |-> !BUS_OE && sel == 0)
        else $error("bus activity in internal states");
    a_sel_window: assert property (
        sel != 0 && $stable(st) |-> st inside {3'h2, 3'h6})
        else $error("select outside transfer state");
    a_one_select: assert property ($onehot0(sel))
        else $error("two selects at once");
    a_state_order: assert property (
        $changed(st) && st inside {3'h4, 3'h5, 3'h6} |-> $past(st) == st - 3'h1)
        else $error("state order broken");
    a_wait_read: assert property (
        (!WAIT_N)[*4] ##0 st == 3'h2 |=> st == 3'h2)
        else $error("left read state under wait");
    a_wait_write: assert property (
        (!WAIT_N)[*4] ##0 st == 3'h6 |=> st == 3'h6 && BUS_OE)
        else $error("write data dropped under wait");
    a_read_t2: assert property (READ_VALID |-> $past(st) == 3'h2)
        else $error("read data outside second state");
    c_write_wait: cover property (st == 3'h6 && !WAIT_N);
    c_dev_sel: cover property (!DEVICE_SELECT_N);
    c_read: cover property (READ_VALID);
endmodule
bind mss_sequencer mss_props mss_props_inst (
    .MCLK(MCLK), .RESET_N(RESET_N), .WAIT_N(WAIT_N), .BUS_OE(BUS_OE),
    .EXT_ADDR_LOAD_STROBE(EXT_ADDR_LOAD_STROBE),
    .MEMORY_SELECT_N(MEMORY_SELECT_N), .DEVICE_SELECT_N(DEVICE_SELECT_N),
    .PANEL_MEMORY_SELECT_N(PANEL_MEMORY_SELECT_N),
    .SWITCH_REG_SELECT_N(SWITCH_REG_SELECT_N),
    .STATE_STATUS(STATE_STATUS), .READ_VALID(READ_VALID));

// File: mss_ext_mem.sv
// far-side model: address latch, memory data and wait
`timescale 1ns/1ps
module mss_ext_mem #(
    parameter int WAIT_LEN = 150
) (
    input  wire logic        clk,
    input  wire logic        strobe,
    input  wire logic [11:0] bus_out,
    input  wire logic        bus_oe,
    input  wire logic [3:0]  sel_n,
    output logic [11:0]      bus_in,
    output logic             wait_n,
    output logic [11:0]      addr_q,
    output logic [11:0]      wdata_q,
    output logic [3:0]       seen_q
);
    logic [3:0]  sel_q = 4'hf;
    logic [11:0] last_q = 12'h0;
    int          cnt_q = 0;
    logic        drive;
    assign drive = !(&sel_n) && !bus_oe;
    assign bus_in = drive ? addr_q ^ 12'h5a5 : ~last_q;
    assign wait_n = (cnt_q == 0);
    always @(posedge clk) begin
        sel_q <= sel_n;
        last_q <= bus_in;
        addr_q <= strobe ? bus_out : addr_q;
        seen_q <= strobe ? 4'h0 : seen_q | ~sel_n;
        if (!(&sel_n) && bus_oe) wdata_q <= bus_out;
        if ((&sel_q) && !(&sel_n)) cnt_q <= WAIT_LEN;
        else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    end
endmodule

// File: mss_sequencer_tb.sv
// self-checking bench for the major-state sequencer
`timescale 1ns/1ps
`include "mss_defs.svh"
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
    $display("ERROR %s exp %h got %h", n, e, a); n_fail++; end end
module cpu_major_state_bus_sequencer_tb
    import mss_pkg::*;
;
    logic        mclk, rst_n, valid, ready, oe, stb, wait_n, skip, full;
    logic        rvalid;
    logic [11:0] bus_in, bus_out, rdata, addr, wdata;
    logic [3:0]  sel_n, seen, sense;
    logic [2:0]  sense_n, req_n, grant, state;
    mss_cycle_t  cyc;
    int          n_fail = 0;
    int          n_compared = 0;
    int          n_rv = 0;
    int          n_t2 = 0;
    mss_sequencer mss_sequencer_inst (
        .MCLK(mclk), .RESET_N(rst_n), .CYCLE_IN(cyc), .CYCLE_VALID(valid),
        .CYCLE_READY(ready), .BUS_IN(bus_in), .BUS_OUT(bus_out),
        .BUS_OE(oe), .EXT_ADDR_LOAD_STROBE(stb),
        .MEMORY_SELECT_N(sel_n[0]), .DEVICE_SELECT_N(sel_n[1]),
        .PANEL_MEMORY_SELECT_N(sel_n[2]), .SWITCH_REG_SELECT_N(sel_n[3]),
        .WAIT_N(wait_n), .PERIPH_SENSE_0_N(sense_n[0]),
        .PERIPH_SENSE_1_N(sense_n[1]), .PERIPH_SENSE_2_N(sense_n[2]),
        .PERIPH_SKIP_SENSE(skip), .REQUEST_N(req_n), .STATE_STATUS(state),
        .READ_DATA(rdata), .READ_VALID(rvalid), .SENSE_OUT(sense),
        .REQUEST_GRANT(grant));
    mss_ext_mem mss_ext_mem_inst (.clk(mclk), .strobe(stb),
        .bus_out(bus_out), .bus_oe(oe), .sel_n(sel_n), .bus_in(bus_in),
        .wait_n(wait_n), .addr_q(addr), .wdata_q(wdata), .seen_q(seen));
    always @(posedge mclk) begin
        if (rvalid === 1'b1) n_rv++;
        if (state === 3'h2) n_t2++;
    end
    task automatic send(input mss_cycle_t c);
        cyc = c;
        valid = 1'b1;
        for (int i = 0; i < 9000 && ready !== 1'b1; i++) @(posedge mclk) #1;
        @(posedge mclk) #1;
        valid = 1'b0;
        @(posedge mclk) #1;
    endtask
    task automatic idle_wait();
        for (int i = 0; i < 600 && state === 3'h0; i++) @(posedge mclk) #1;
        for (int i = 0; i < 9000 && state !== 3'h0; i++) @(posedge mclk) #1;
    endtask
    task automatic go(input mss_cycle_t c);
        send(c);
        idle_wait();
        `CHK("addr", c.word, addr)
    endtask
    task automatic t_read();
        go('{12'h123, 12'h0, 1'b0, 1'b1, 1'b0, `MSS_TGT_MEM, 1'b0});
        `CHK("rdata", 12'h486, rdata)
        `CHK("mem sel", 4'h1, seen)
        `CHK("read valid", 1, n_rv)
        `CHK("t2 length", 4 * `MSS_XTAL_DIV, n_t2)
    endtask
    task automatic t_io();
        sense_n = 3'b010;
        skip = 1'b1;
        go('{12'hc05, 12'h0, 1'b1, 1'b1, 1'b0, `MSS_TGT_MEM, 1'b0});
        `CHK("sense", 4'hb, sense)
        `CHK("dev sel", 4'h2, seen)
    endtask
    task automatic t_write();
        int rv0;
        rv0 = n_rv;
        go('{12'h456, 12'h3c3, 1'b0, 1'b0, 1'b1, `MSS_TGT_MEM, 1'b0});
        `CHK("wdata", 12'h3c3, wdata)
        `CHK("no read", rv0, n_rv)
    endtask
    task automatic t_targets();
        for (int t = 1; t < 3; t++) begin
            go('{12'h0a0, 12'h0, 1'b0, 1'b1, 1'b0, 2'(t), 1'b0});
            `CHK("target sel", 4'h2 << t, seen)
        end
    endtask
    task automatic t_request();
        req_n = 3'b001;
        go('{12'h010, 12'h0, 1'b0, 1'b1, 1'b0, `MSS_TGT_MEM, 1'b0});
        `CHK("no grant", 3'h0, grant)
        go('{12'h011, 12'h0, 1'b0, 1'b1, 1'b0, `MSS_TGT_MEM, 1'b1});
        `CHK("grant", 3'h2, grant)
        req_n = 3'h7;
    endtask
    task automatic t_fill();
        full = 1'b0;
        for (int k = 0; k < 10; k++) begin
            if (ready !== 1'b1) full = 1'b1;
            send('{12'h200 + 12'(k), 12'h0, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0});
        end
        repeat (10) idle_wait();
        `CHK("fifo full", 1'b1, full)
        `CHK("last addr", 12'h209, addr)
    endtask
    task automatic results();
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #200000;
        n_fail++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        valid = 1'b0;
        cyc = '0;
        sense_n = 3'h7;
        skip = 1'b0;
        req_n = 3'h7;
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge mclk) #1;
        t_read();
        t_io();
        t_write();
        t_targets();
        t_request();
        t_fill();
        results();
    end
endmodule
